// file: src/pnf_pkg.sv
// Package for the parallel NOR flash host controller.
// Assumes a 100 MHz system clock; flash pins are asynchronous to it.
package pnf_pkg;
    // =========================================
    // Clock and timing
    localparam int CLK_PERIOD_NS      = 10;
    localparam int RANDOM_ACCESS_NS   = 90;   // random_access_delay
    localparam int PAGE_ACCESS_NS     = 25;   // page_access_delay
    localparam int WRITE_PULSE_NS     = 50;
    localparam int RESET_PULSE_NS     = 500;
    localparam int RANDOM_ACCESS_CYC  = (RANDOM_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PAGE_ACCESS_CYC    = (PAGE_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_PULSE_CYC    = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_PULSE_CYC    = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // =========================================
    // Geometry
    localparam int ADDR_W      = 24;
    localparam int DATA_W      = 16;
    localparam int PAGE_BITS   = 3;
    localparam int SECTOR_BITS = 8;
    localparam int CNT_W       = 8;
    // =========================================
    // Command sequence defaults (override through module parameters)
    localparam logic [15:0] UNLOCK_DATA1 = 16'h00aa;
    localparam logic [15:0] UNLOCK_DATA2 = 16'h0055;
    localparam logic [23:0] UNLOCK_ADDR1 = 24'h000555;
    localparam logic [23:0] UNLOCK_ADDR2 = 24'h0002aa;
    localparam logic [15:0] CMD_PROGRAM  = 16'h00a0;
    localparam logic [15:0] CMD_AUTOSEL  = 16'h0090;
    localparam logic [15:0] CMD_RESET    = 16'h00f0;
    localparam logic [15:0] STATUS_TOGGLE_MASK = 16'h0040;
    // =========================================
    // Host operations
    typedef enum logic [2:0] {
        OP_READ, OP_PROGRAM, OP_AUTOSEL, OP_IDREAD, OP_EXIT
    } pnf_op_type;
    typedef enum {
        ST_IDLE, ST_RD_WAIT, ST_RD_PAGE, ST_WR_SETUP, ST_WR_PULSE, ST_WR_HOLD,
        ST_POLL, ST_HWRESET
    } pnf_state_type;
endpackage

// file: src/pnf_host.sv
// Host-side controller that drives a parallel NOR flash through its pins.
// Assumes one 100 MHz clock; flash data inputs are synchronised here.
`timescale 1ns/100ps
// What this block does
// - Reads drive address, chip select and output enable low, write strobe high.
// - Writes drive chip select and write strobe low, output enable high.
// - Autoselect only issued while device reads, never during program.
// - Reset command leaves autoselect back to read state.
// - Protection check puts sector address on top address bits.
// - Hardware reset is taken only in idle, never during a program; caller then reissues sequence.
// - Single word program is a four-write sequence; poll status bits.
module pnf_host #(
    parameter logic [15:0] UNLOCK_DATA1 = pnf_pkg::UNLOCK_DATA1,
    parameter logic [15:0] UNLOCK_DATA2 = pnf_pkg::UNLOCK_DATA2,
    parameter logic [23:0] UNLOCK_ADDR1 = pnf_pkg::UNLOCK_ADDR1,
    parameter logic [23:0] UNLOCK_ADDR2 = pnf_pkg::UNLOCK_ADDR2,
    parameter logic [15:0] CMD_PROGRAM  = pnf_pkg::CMD_PROGRAM,
    parameter logic [15:0] CMD_AUTOSEL  = pnf_pkg::CMD_AUTOSEL,
    parameter logic [15:0] CMD_RESET    = pnf_pkg::CMD_RESET
) (
    input  wire logic                          mclk,         // System clock
    input  wire logic                          sys_rst,      // Sync reset, high
    input  wire logic                          reqValid,     // Request strobe
    input  wire logic [2:0]                    reqOp,        // pnf_op_type code
    input  wire logic [pnf_pkg::ADDR_W-1:0]    reqAddr,      // Word address
    input  wire logic [pnf_pkg::DATA_W-1:0]    reqData,      // Program data
    input  wire logic                          byteMode,     // 1 selects byte width
    input  wire logic                          hwResetReq,   // Pulse reset of flash
    input  wire logic                          unprotect,    // Releases outer sector
    output logic                               reqReady,     // Idle, accepts request
    output logic                               rspValid,     // One-cycle answer
    output logic [pnf_pkg::DATA_W-1:0]         rspData,      // Read data
    output logic                               flashBusy,    // Embedded op running
    output logic [pnf_pkg::ADDR_W-1:0]         flashAddr,    // Address pins
    output logic                               chipSelect_n, // Chip select
    output logic                               outEnable_n,  // Output enable
    output logic                               writeStrobe_n,// Write strobe
    output logic                               hwReset_n,    // Hardware reset pin
    output logic                               widthSelect_n,// High for word width
    output logic                               protect_accel_pin, // Protect pin
    output logic [pnf_pkg::DATA_W-1:0]         dqOut,        // Data pins out
    output logic                               dqOe,         // Data pins drive
    output logic                               topDataOe,    // top_data_or_low_addr drive
    input  wire logic [pnf_pkg::DATA_W-1:0]    dqIn          // Data pins in
);
    // =========================================
    // Input synchroniser
    logic [pnf_pkg::DATA_W-1:0] dqMeta;
    logic [pnf_pkg::DATA_W-1:0] dqSync;
    always_ff @(posedge mclk) begin
        dqMeta <= dqIn;
        dqSync <= dqMeta;
    end

    // =========================================
    // Sequencer
    pnf_pkg::pnf_state_type state;
    pnf_pkg::pnf_op_type    op;
    localparam int CNT_W_L = pnf_pkg::CNT_W;
    logic [CNT_W_L-1:0]     cnt;
    logic [1:0]             step;
    logic [1:0]             lastStep;
    logic                   idMode;
    logic                   pageValid;
    logic [pnf_pkg::DATA_W-1:0] lastPoll;
    logic [pnf_pkg::ADDR_W-1:0] tgtAddr;
    logic [pnf_pkg::DATA_W-1:0] tgtData;
    logic                   pollFirst;
    localparam logic [CNT_W_L-1:0] RD_CYC = CNT_W_L'(pnf_pkg::RANDOM_ACCESS_CYC + 2);
    localparam logic [CNT_W_L-1:0] PG_CYC = CNT_W_L'(pnf_pkg::PAGE_ACCESS_CYC + 2);
    localparam logic [CNT_W_L-1:0] WP_CYC = CNT_W_L'(pnf_pkg::WRITE_PULSE_CYC);
    localparam logic [CNT_W_L-1:0] RS_CYC = CNT_W_L'(pnf_pkg::RESET_PULSE_CYC);
    localparam logic [CNT_W_L-1:0] ONE    = CNT_W_L'(1);

    logic samePage;
    assign samePage = pageValid &&
        (flashAddr[pnf_pkg::ADDR_W-1:pnf_pkg::PAGE_BITS] ==
         reqAddr[pnf_pkg::ADDR_W-1:pnf_pkg::PAGE_BITS]);

    // Address and data of each step of a command sequence
    function automatic logic [39:0] seqWord(input pnf_pkg::pnf_op_type o, input logic [1:0] s,
                                            input logic [23:0] a, input logic [15:0] d);
        logic [39:0] w;
        w = {UNLOCK_ADDR1, CMD_RESET};
        case (s)
            2'h0: w = {UNLOCK_ADDR1, UNLOCK_DATA1};
            2'h1: w = {UNLOCK_ADDR2, UNLOCK_DATA2};
            2'h2: w = (o == pnf_pkg::OP_PROGRAM) ? {UNLOCK_ADDR1, CMD_PROGRAM}
                                                 : {a, CMD_AUTOSEL};
            2'h3: w = {a, d};
            default: w = {UNLOCK_ADDR1, CMD_RESET};
        endcase
        if (o == pnf_pkg::OP_EXIT) begin
            w = {UNLOCK_ADDR1, CMD_RESET};
        end
        return w;
    endfunction

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state <= pnf_pkg::ST_HWRESET;
            op <= pnf_pkg::OP_READ;
            cnt <= RS_CYC;
            step <= 2'h0;
            lastStep <= 2'h0;
            idMode <= 1'b0;
            pageValid <= 1'b0;
            lastPoll <= 16'h0000;
            pollFirst <= 1'b0;
            tgtAddr <= 24'h000000;
            tgtData <= 16'h0000;
            reqReady <= 1'b0;
            rspValid <= 1'b0;
            rspData <= 16'h0000;
            flashBusy <= 1'b0;
            flashAddr <= 24'h000000;
            chipSelect_n <= 1'b1;
            outEnable_n <= 1'b1;
            writeStrobe_n <= 1'b1;
            hwReset_n <= 1'b0;
            dqOut <= 16'h0000;
            dqOe <= 1'b0;
        end else begin
            rspValid <= 1'b0;
            case (state)
                pnf_pkg::ST_IDLE: begin
                    if (hwResetReq) begin
                        // Only taken in idle, so never during an embedded program; caller reissues it
                        hwReset_n <= 1'b0;
                        chipSelect_n <= 1'b1;
                        outEnable_n <= 1'b1;
                        pageValid <= 1'b0;
                        reqReady <= 1'b0;
                        cnt <= RS_CYC;
                        state <= pnf_pkg::ST_HWRESET;
                    end else if (reqValid) begin
                        op <= pnf_pkg::pnf_op_type'(reqOp);
                        tgtAddr <= reqAddr;
                        tgtData <= reqData;
                        reqReady <= 1'b0;
                        step <= 2'h0;
                        if (reqOp == pnf_pkg::OP_READ || reqOp == pnf_pkg::OP_IDREAD) begin
                            // Keep chip select low within a page for fast access
                            flashAddr <= reqAddr;
                            outEnable_n <= 1'b0;
                            writeStrobe_n <= 1'b1;
                            dqOe <= 1'b0;
                            // A new page needs a fresh chip select fall to latch it
                            chipSelect_n <= !samePage;
                            cnt <= samePage ? PG_CYC : RD_CYC;
                            pageValid <= 1'b1;
                            state <= pnf_pkg::ST_RD_WAIT;
                        end else begin
                            chipSelect_n <= 1'b1;
                            outEnable_n <= 1'b1;
                            pageValid <= 1'b0;
                            lastStep <= (reqOp == pnf_pkg::OP_PROGRAM) ? 2'h3 :
                                        (reqOp == pnf_pkg::OP_AUTOSEL) ? 2'h2 : 2'h0;
                            state <= pnf_pkg::ST_WR_SETUP;
                        end
                    end
                end
                pnf_pkg::ST_RD_WAIT: begin
                    chipSelect_n <= 1'b0;
                    if (cnt == ONE) begin
                        rspData <= byteMode ? {8'h00, dqSync[7:0]} : dqSync;
                        rspValid <= 1'b1;
                        reqReady <= 1'b1;
                        state <= pnf_pkg::ST_IDLE;
                    end
                    cnt <= cnt - ONE;
                end
                pnf_pkg::ST_WR_SETUP: begin
                    // Address first, output enable high, then strobe
                    {flashAddr, dqOut} <= seqWord(op, step, tgtAddr, tgtData);
                    dqOe <= 1'b1;
                    outEnable_n <= 1'b1;
                    chipSelect_n <= 1'b0;
                    cnt <= WP_CYC;
                    state <= pnf_pkg::ST_WR_PULSE;
                end
                pnf_pkg::ST_WR_PULSE: begin
                    writeStrobe_n <= 1'b0;
                    if (cnt == ONE) begin
                        state <= pnf_pkg::ST_WR_HOLD;
                    end
                    cnt <= cnt - ONE;
                end
                pnf_pkg::ST_WR_HOLD: begin
                    // Strobe and chip select rise; after the last step data drive drops on the same edge
                    writeStrobe_n <= 1'b1;
                    chipSelect_n <= 1'b1;
                    if (!writeStrobe_n) begin
                        if (step == lastStep) begin
                            dqOe <= 1'b0;
                            if (op == pnf_pkg::OP_PROGRAM) begin
                                // Data polling watches the toggle bit at the target
                                flashBusy <= 1'b1;
                                flashAddr <= tgtAddr;
                                lastPoll <= 16'h0000;
                                pollFirst <= 1'b1;
                                cnt <= RD_CYC;
                                state <= pnf_pkg::ST_POLL;
                            end else begin
                                idMode <= (op == pnf_pkg::OP_AUTOSEL);
                                reqReady <= 1'b1;
                                rspValid <= 1'b1;
                                state <= pnf_pkg::ST_IDLE;
                            end
                        end else begin
                            step <= step + 2'h1;
                            state <= pnf_pkg::ST_WR_SETUP;
                        end
                    end
                end
                pnf_pkg::ST_POLL: begin
                    // Only reads during the embedded program; no commands
                    chipSelect_n <= 1'b0;
                    outEnable_n <= 1'b0;
                    if (cnt == ONE) begin
                        chipSelect_n <= 1'b1;
                        outEnable_n <= 1'b1;
                        lastPoll <= dqSync;
                        pollFirst <= 1'b0;
                        cnt <= RD_CYC;
                        // First sample has nothing to compare with; it never ends the poll, even with bit 6 at zero
                        if (((dqSync ^ lastPoll) & pnf_pkg::STATUS_TOGGLE_MASK) == 16'h0000 &&
                            !pollFirst) begin
                            flashBusy <= 1'b0;
                            rspData <= dqSync;
                            rspValid <= 1'b1;
                            reqReady <= 1'b1;
                            state <= pnf_pkg::ST_IDLE;
                        end
                    end else begin
                        cnt <= cnt - ONE;
                    end
                end
                pnf_pkg::ST_HWRESET: begin
                    flashBusy <= 1'b0;
                    idMode <= 1'b0;
                    dqOe <= 1'b0;
                    writeStrobe_n <= 1'b1;
                    if (cnt == ONE) begin
                        hwReset_n <= 1'b1;
                        reqReady <= 1'b1;
                        state <= pnf_pkg::ST_IDLE;
                    end
                    cnt <= cnt - ONE;
                end
                default: begin
                    state <= pnf_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // =========================================
    // Static pins
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            widthSelect_n <= 1'b1;
            protect_accel_pin <= 1'b0;
            topDataOe <= 1'b0;
        end else begin
            widthSelect_n <= !byteMode;
            protect_accel_pin <= unprotect;
            topDataOe <= byteMode || dqOe;
        end
    end
endmodule

// file: testbench/pnf_flash_model.sv
// Behavioural parallel NOR flash that answers the host controller's pins.
// Assumes word-wide command cycles; data is prompt, busy spans three status reads.
`timescale 1ns/100ps
module pnf_flash_model #(
    parameter logic [15:0] MAKER_CODE = 16'h005a, // Arbitrary value
    parameter logic [15:0] PART_CODE  = 16'h0033  // Arbitrary value
) (
    input  wire logic [23:0] flashAddr,         // Address pins
    input  wire logic        chipSelect_n,      // Chip select
    input  wire logic        outEnable_n,       // Output enable
    input  wire logic        writeStrobe_n,     // Write strobe
    input  wire logic        hwReset_n,         // Hardware reset
    input  wire logic        widthSelect_n,     // Low for byte width
    input  wire logic        protect_accel_pin, // Protect pin
    input  wire logic [15:0] dqOut,             // Host data
    output logic      [15:0] dqIn               // Device data
);
    logic [15:0] mem [logic [23:0]];
    logic [15:0] rd;
    logic [15:0] last   = 16'h0000;
    logic [1:0]  step   = 2'h0;
    logic        idMode = 1'b0;
    logic        tog    = 1'b0;
    logic [23:0] wa;
    logic [23:0] ra     = 24'h000000;
    logic        inCyc  = 1'b0;
    wire  [23:0] ea     = {ra[23:pnf_pkg::PAGE_BITS], flashAddr[pnf_pkg::PAGE_BITS-1:0]};
    int          busy   = 0;
    // ==========================================
    // Write cycles
    function automatic logic [15:0] rdw(input logic [23:0] a);
        return mem.exists(a) ? mem[a] : 16'hffff;
    endfunction
    task automatic take(input logic [15:0] d);
        if (busy > 0 || !hwReset_n) return;
        if (step == 2'h3) begin
            mem[wa] = rdw(wa) & d;
            busy = 4;
            step = 2'h0;
        end else if (d == pnf_pkg::CMD_RESET) begin
            idMode = 1'b0;
            step = 2'h0;
        end else if (step == 2'h0 && d == pnf_pkg::UNLOCK_DATA1) step = 2'h1;
        else if (step == 2'h1 && d == pnf_pkg::UNLOCK_DATA2) step = 2'h2;
        else if (step == 2'h2 && d == pnf_pkg::CMD_PROGRAM) step = 2'h3;
        else if (step == 2'h2 && d == pnf_pkg::CMD_AUTOSEL) begin
            idMode = 1'b1;
            step = 2'h0;
        end else step = 2'h0;
    endtask
    always @(negedge writeStrobe_n or negedge chipSelect_n)
        if (!writeStrobe_n && !chipSelect_n) begin
            wa = flashAddr;
            inCyc = 1'b1;
        end
    // Both strobes may rise in one step; the flag keeps it to one data capture
    always @(posedge writeStrobe_n or posedge chipSelect_n)
        if (inCyc) begin
            inCyc = 1'b0;
            take(dqOut);
        end
    // Page bits stay latched while chip select is held low
    always @(negedge chipSelect_n) ra = flashAddr;
    always @(negedge hwReset_n) begin
        idMode = 1'b0;
        inCyc = 1'b0;
        step = 2'h0;
        busy = 0;
    end
    // ==========================================
    // Read path
    always @(negedge outEnable_n)
        if (busy > 0) begin
            busy = busy - 1;
            tog = ~tog;
        end
    always @* begin
        if (busy > 0) rd = {9'h000, tog, 6'h00};
        else if (idMode && ea[7:0] == 8'h00) rd = MAKER_CODE;
        else if (idMode && ea[7:0] == 8'h01) rd = PART_CODE;
        else if (idMode) rd = {15'h0000, ea[23:16] == 8'hff && !protect_accel_pin};
        else rd = rdw(ea);
    end
    always @(posedge outEnable_n) last = rd;
    // Released lines show the inverse of the last value, never a stale copy
    assign dqIn = (!chipSelect_n && !outEnable_n && hwReset_n) ?
                  (widthSelect_n ? rd : {~last[15:8], rd[7:0]}) : ~last;
endmodule

// file: testbench/pnf_host_chk.sv
// Pin-level checker for the NOR flash host controller.
// Assumes it is bound into pnf_host and sees only its ports.
`timescale 1ns/100ps
module pnf_host_chk (
    input wire logic       mclk,              // Clock
    input wire logic       sys_rst,           // Reset
    input wire logic       reqValid,          // Request strobe
    input wire logic [2:0] reqOp,             // Operation
    input wire logic       reqReady,          // Idle
    input wire logic       rspValid,          // Answer
    input wire logic       flashBusy,         // Embedded op running
    input wire logic       chipSelect_n,      // Chip select
    input wire logic       outEnable_n,       // Output enable
    input wire logic       writeStrobe_n,     // Write strobe
    input wire logic       hwReset_n,         // Flash reset
    input wire logic       hwResetReq,        // Reset request
    input wire logic       unprotect,         // Protect release
    input wire logic       protect_accel_pin, // Protect pin
    input wire logic       dqOe               // Data drive
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // ==========================================
    // Bus states
    read_pins_a: assert property (!chipSelect_n && !outEnable_n |-> writeStrobe_n && hwReset_n)
        else $error("read state with write or reset active");
    write_pins_a: assert property (!writeStrobe_n |-> !chipSelect_n && outEnable_n && dqOe)
        else $error("write strobe without select or data drive");
    no_contend_a: assert property (dqOe |-> outEnable_n)
        else $error("host drives data while output enabled");
    read_answer_a: assert property (reqValid && reqReady && reqOp == 3'h0 |-> ##[4:12] rspValid)
        else $error("read answer late");
    busy_quiet_a: assert property (flashBusy |-> writeStrobe_n)
        else $error("write cycle during embedded operation");
    // ==========================================
    // Reset and protect
    hw_pulse_a: assert property (hwResetReq && reqReady |-> ##[1:2] !hwReset_n)
        else $error("reset request did not reach the pin");
    hw_float_a: assert property (!hwReset_n |-> !dqOe)
        else $error("data driven during flash reset");
    boot_hold_a: assert property ($fell(sys_rst) |-> !reqReady [*8])
        else $error("ready before flash reset pulse ended");
    protect_pin_a: assert property ($rose(unprotect) |-> ##[0:2] protect_accel_pin)
        else $error("protect pin did not follow");
endmodule
bind pnf_host pnf_host_chk u_pnf_host_chk (.mclk, .sys_rst, .reqValid, .reqOp, .reqReady,
    .rspValid, .flashBusy, .chipSelect_n, .outEnable_n, .writeStrobe_n, .hwReset_n,
    .hwResetReq, .unprotect, .protect_accel_pin, .dqOe);

// file: testbench/tb_pnf_host.sv
// Self-checking bench for the NOR flash host controller and a flash model.
// Assumes the model and checker files are compiled before this one.
`timescale 1ns/100ps
module tb_pnf_host;
    localparam logic [15:0] MAKER_CODE = 16'h005a; // Arbitrary value
    localparam logic [15:0] PART_CODE  = 16'h0033; // Arbitrary value
    logic        mclk, sys_rst, reqValid, byteMode, hwResetReq, unprotect, reqReady;
    logic        rspValid, flashBusy, chipSelect_n, outEnable_n, writeStrobe_n, hwReset_n;
    logic        widthSelect_n, protect_accel_pin, dqOe, topDataOe;
    logic [2:0]  reqOp;
    logic [23:0] reqAddr, flashAddr;
    logic [15:0] reqData, rspData, dqOut, dqIn, q;
    int          mismatches, total_checks, l1, l2, l3;
    pnf_host u_pnf_host (.mclk, .sys_rst, .reqValid, .reqOp, .reqAddr, .reqData, .byteMode,
        .hwResetReq, .unprotect, .reqReady, .rspValid, .rspData, .flashBusy, .flashAddr,
        .chipSelect_n, .outEnable_n, .writeStrobe_n, .hwReset_n, .widthSelect_n,
        .protect_accel_pin, .dqOut, .dqOe, .topDataOe, .dqIn);
    pnf_flash_model #(.MAKER_CODE(MAKER_CODE), .PART_CODE(PART_CODE)) u_pnf_flash_model (
        .flashAddr, .chipSelect_n, .outEnable_n, .writeStrobe_n, .hwReset_n, .widthSelect_n,
        .protect_accel_pin, .dqOut, .dqIn);
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // ==========================================
    // Shared tasks
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic req(input logic [2:0] op, input logic [23:0] a, input logic [15:0] d,
                       output int lat);
        int n;
        n = 0;
        while (reqReady !== 1'b1 && n < 300) begin
            @(posedge mclk);
            #1;
            n++;
        end
        reqOp = op;
        reqAddr = a;
        reqData = d;
        reqValid = 1'b1;
        @(posedge mclk);
        #1;
        reqValid = 1'b0;
        lat = 1;
        while (rspValid !== 1'b1 && lat < 3000) begin
            @(posedge mclk);
            #1;
            lat++;
        end
        chk("answer", 16'h0001, {15'h0000, rspValid});
        q = rspData;
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // ==========================================
    // Scenarios
    task automatic t_prog;
        req(3'h0, 24'h000123, 16'h0000, l1);
        chk("boot read", 16'hffff, q);
        req(3'h1, 24'h000123, 16'h12f0, l1);
        chk("busy after program", 16'h0000, {15'h0000, flashBusy});
        req(3'h0, 24'h000123, 16'h0000, l1);
        chk("program", 16'h12f0, q);
        req(3'h1, 24'h000123, 16'hff0f, l1);
        req(3'h0, 24'h000123, 16'h0000, l1);
        chk("reprogram", 16'h1200, q);
        req(3'h1, 24'h7f0125, 16'h0a5a, l1);
        req(3'h0, 24'h7f0125, 16'h0000, l1);
        chk("other sector", 16'h0a5a, q);
        $display("program test done");
    endtask
    task automatic t_page;
        req(3'h0, 24'h000120, 16'h0000, l1);
        req(3'h0, 24'h000123, 16'h0000, l2);
        chk("page data", 16'h1200, q);
        req(3'h0, 24'h7f0125, 16'h0000, l3);
        chk("page faster", 16'h0001, {15'h0000, l2 < l1});
        chk("new page full", 16'h0001, {15'h0000, l3 > l2});
        $display("page test done");
    endtask
    task automatic t_autosel;
        unprotect = 1'b0;
        req(3'h2, 24'h000000, 16'h0000, l1);
        req(3'h3, 24'h000000, 16'h0000, l1);
        chk("maker code", MAKER_CODE, q);
        req(3'h3, 24'h000001, 16'h0000, l1);
        chk("part code", PART_CODE, q);
        req(3'h3, 24'hff4c02, 16'h0000, l1);
        chk("outer protected", 16'h0001, q);
        unprotect = 1'b1;
        req(3'h3, 24'hff0002, 16'h0000, l1);
        chk("outer open", 16'h0000, q);
        req(3'h4, 24'h000000, 16'h0000, l1);
        req(3'h0, 24'h000123, 16'h0000, l1);
        chk("exit to array", 16'h1200, q);
        $display("autoselect test done");
    endtask
    task automatic t_hwreset;
        int n;
        req(3'h2, 24'h000000, 16'h0000, l1);
        hwResetReq = 1'b1;
        @(posedge mclk);
        #1;
        hwResetReq = 1'b0;
        n = 0;
        repeat (80) begin
            @(posedge mclk);
            #1;
            if (hwReset_n === 1'b0) n++;
        end
        chk("reset pulse seen", 16'h0001, {15'h0000, n > 0});
        req(3'h0, 24'h000123, 16'h0000, l1);
        chk("array after reset", 16'h1200, q);
        byteMode = 1'b1;
        req(3'h0, 24'h7f0125, 16'h0000, l1);
        chk("byte read", 16'h005a, q);
        chk("width pin", 16'h0000, {15'h0000, widthSelect_n});
        chk("top pin drive", 16'h0001, {15'h0000, topDataOe});
        byteMode = 1'b0;
        $display("reset and byte test done");
    endtask
    initial begin
        {sys_rst, reqValid, byteMode, hwResetReq, unprotect} = 5'b10001;
        {reqOp, reqAddr, reqData} = '0;
        {mismatches, total_checks} = '0;
        repeat (4) @(posedge mclk);
        #1;
        sys_rst = 1'b0;
        t_prog();
        t_page();
        t_autosel();
        t_hwreset();
        summarize();
    end
    initial begin
        #400000;
        mismatches++;
        summarize();
    end
endmodule
